// ---- pfs_pkg.sv ----
// Purpose: Constants for the port 1 / port 2 pin function select block
// Assumes: 32-bit AXI4-Lite register window, byte addressed
// Notes:   Offsets are byte addresses from the system control base
package pfs_pkg;

  // Register window
  localparam int          ADDR_W              = 12;
  localparam logic [11:0] PORT1_CTRL_OFFSET   = 12'h034;
  localparam logic [11:0] PORT2_CTRL_OFFSET   = 12'h038;
  localparam logic [31:0] PORT1_CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] PORT2_CTRL_RESET    = 32'h0000_0000;

  // Implemented bits; everything else is reserved and reads zero
  localparam logic [31:0] PORT1_CTRL_MASK     = 32'h00ff_00ff;
  localparam logic [31:0] PORT2_CTRL_MASK     = 32'h00ff_f1ff;

  // Field positions
  localparam int          SEL_LSB             = 0;
  localparam int          ALT_LSB             = 8;
  localparam int          SCHMITT_LSB         = 16;
  localparam int          P1_BRAKE1_PIN       = 7;
  localparam int          P1_BRAKE0_PIN       = 6;
  localparam int          P1_PWM_PINS         = 6;
  localparam int          PORT2_ALTERNATE_SELECT_PIN7         = 15;
  localparam int          P2_SEL_PIN7         = 7;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

  // Port 2 pin 7 function
  typedef enum logic [1:0] {
    PFS_P27_GPIO,
    PFS_P27_SPI_SCLK,
    PFS_P27_UART_RTS
  } pfs_p27_func_t;

endpackage : pfs_pkg

// ---- pfs_pin_select.sv ----
// Purpose: Function select for port 1 pins and port 2 pin 7; Schmitt enable for ports 1 and 2
// Assumes: AXI4-Lite master keeps valid/payload stable until ready
// Notes:   Pin routing is registered, so a change lands one cycle late
//
// Notes on behaviour
// - Port 1 Schmitt enable for pin m follows control bit m+16.
// - Port 1 pin 7 is GPIO at select 0, PWM unit 1 brake 0 at 1.
// - Port 1 pin 6 is GPIO at select 0, PWM unit 0 brake 0 at 1.
// - Port 1 pins 0 to 5 are GPIO at 0, PWM unit 1 channel n at 1.
// - Port 2 Schmitt enable for pin m follows bits 23 down to 16.
// - Port 2 alternate bits 15,14,13,12,8 pair with pins 7,6,5,4,0.
// - Port 2 pin 7: 00 GPIO, 10 SPI 0 clock, 11 UART 1 RTS.
// - Port 1 control at 0x34, read/write, resets to zero.
// - Port 2 control at 0x38, read/write, resets to zero.
`timescale 1ns/10ps

module pfs_pin_select (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Port 1 pins
  input  wire logic [7:0]  port1_pin_in,
  output logic [7:0]       port1_pin_out,
  output logic [7:0]       port1_pin_oe_out,
  output logic [7:0]       port1_schmitt_enable_out,
  // Port 2 pins
  input  wire logic [7:0]  port2_pin_in,
  output logic [7:0]       port2_pin_out,
  output logic [7:0]       port2_pin_oe_out,
  output logic [7:0]       port2_schmitt_enable_out,
  // GPIO controller side
  input  wire logic [7:0]  gpio_port1_out_in,
  input  wire logic [7:0]  gpio_port1_oe_in,
  input  wire logic [7:0]  gpio_port2_out_in,
  input  wire logic [7:0]  gpio_port2_oe_in,
  output logic [7:0]       gpio_port1_pin_out,
  output logic [7:0]       gpio_port2_pin_out,
  // PWM units
  input  wire logic [5:0]  pwm_unit1_out_in,
  output logic             pwm_unit1_brake_in0_out,
  output logic             pwm_unit0_brake_in0_out,
  // SPI unit 0 clock
  input  wire logic        serial_periph0_sclk_in,
  input  wire logic        serial_periph0_sclk_oe_in,
  output logic             serial_periph0_sclk_out,
  // UART unit 1
  input  wire logic        uart_unit1_rts_out_in,
  // Decoded selections
  output logic [7:0]       port1_function_select_out,
  output logic [1:0]       port2_pin7_function_out
);

  typedef struct packed {
    logic                   aw_have;
    logic [11:0]            aw_addr;
    logic                   w_have;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [31:0]            port1_ctrl;
    logic [31:0]            port2_ctrl;
    logic [7:0]             p1_out;
    logic [7:0]             p1_oe;
    logic [7:0]             p2_out;
    logic [7:0]             p2_oe;
    logic [7:0]             gpio_p1;
    logic [7:0]             gpio_p2;
    logic                   brake1;
    logic                   brake0;
    logic                   sclk;
    pfs_pkg::pfs_p27_func_t p27;
  } pfs_state_t;

  pfs_state_t state_q;
  pfs_state_t state_d;

  // Masking here keeps reserved bits at zero whatever the strobes say
  // Byte-lane merge; only implemented bits take the new value
  function automatic logic [31:0] pfs_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    pfs_merge = ((old_val & ~lane) | (new_val & lane)) & mask;
  endfunction : pfs_merge

  logic [7:0]             p1_sel;
  logic [7:0]             p2_sel;
  logic [7:0]             port2_alternate_select;
  logic                   wr_fire;
  logic                   rd_fire;
  pfs_pkg::pfs_p27_func_t p27_func;

  always_comb
  begin
    state_d = state_q;
    p1_sel  = state_q.port1_ctrl[pfs_pkg::SEL_LSB +: 8];
    p2_sel  = state_q.port2_ctrl[pfs_pkg::SEL_LSB +: 8];
    port2_alternate_select  = state_q.port2_ctrl[pfs_pkg::ALT_LSB +: 8];

    // Address and data are caught independently, in either order
    if (s_axi_awvalid_in && state_q.awready)
    begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && state_q.wready)
    begin
      state_d.w_have = 1'b1;
      state_d.w_data = s_axi_wdata_in;
      state_d.w_strb = s_axi_wstrb_in;
    end

    // Response goes out once both halves are held
    wr_fire = state_q.aw_have && state_q.w_have && !state_q.bvalid;
    if (wr_fire)
    begin
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = pfs_pkg::RESP_OKAY;
      // Unmapped offsets answer SLVERR and leave both registers alone
      case ({state_q.aw_addr[11:2], 2'b00})
        pfs_pkg::PORT1_CTRL_OFFSET:
        begin
          state_d.port1_ctrl = pfs_merge(state_q.port1_ctrl, state_q.w_data,
                                         state_q.w_strb,
                                         pfs_pkg::PORT1_CTRL_MASK);
        end
        pfs_pkg::PORT2_CTRL_OFFSET:
        begin
          state_d.port2_ctrl = pfs_merge(state_q.port2_ctrl, state_q.w_data,
                                         state_q.w_strb,
                                         pfs_pkg::PORT2_CTRL_MASK);
        end
        default:
        begin
          state_d.bresp = pfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (state_q.bvalid && s_axi_bready_in)
    begin
      state_d.bvalid = 1'b0;
    end

    // Ready drops while a half is held, so nothing is overwritten
    state_d.awready = !state_d.aw_have && !state_d.bvalid;
    state_d.wready  = !state_d.w_have && !state_d.bvalid;

    // Read channel: one read outstanding at a time
    // Answer stands from the same edge that takes the address
    rd_fire = s_axi_arvalid_in && state_q.arready;
    if (rd_fire)
    begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = pfs_pkg::RESP_OKAY;
      case ({s_axi_araddr_in[11:2], 2'b00})
        pfs_pkg::PORT1_CTRL_OFFSET:
        begin
          state_d.rdata = state_q.port1_ctrl & pfs_pkg::PORT1_CTRL_MASK;
        end
        pfs_pkg::PORT2_CTRL_OFFSET:
        begin
          state_d.rdata = state_q.port2_ctrl & pfs_pkg::PORT2_CTRL_MASK;
        end
        default:
        begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = pfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (state_q.rvalid && s_axi_rready_in)
    begin
      state_d.rvalid = 1'b0;
    end
    // Address is refused while an answer stands
    state_d.arready = !state_d.rvalid;

    // Port 1 default: GPIO on every pin
    state_d.p1_out  = gpio_port1_out_in;
    state_d.p1_oe   = gpio_port1_oe_in;
    state_d.gpio_p1 = port1_pin_in;

    // PWM unit 1 channels drive pins 0 to 5
    for (int n = 0; n < pfs_pkg::P1_PWM_PINS; n++)
    begin
      if (p1_sel[n])
      begin
        state_d.p1_out[n] = pwm_unit1_out_in[n];
        state_d.p1_oe[n]  = 1'b1;
      end
    end

    // Brake pins are inputs; pad released, brake idles low when unrouted
    // Driving a brake pad would fight the external fault source
    state_d.brake1 = 1'b0;
    state_d.brake0 = 1'b0;
    if (p1_sel[pfs_pkg::P1_BRAKE1_PIN])
    begin
      state_d.p1_oe[pfs_pkg::P1_BRAKE1_PIN] = 1'b0;
      state_d.brake1 = port1_pin_in[pfs_pkg::P1_BRAKE1_PIN];
    end
    if (p1_sel[pfs_pkg::P1_BRAKE0_PIN])
    begin
      state_d.p1_oe[pfs_pkg::P1_BRAKE0_PIN] = 1'b0;
      state_d.brake0 = port1_pin_in[pfs_pkg::P1_BRAKE0_PIN];
    end

    // Port 2: pins 6 to 0 stay GPIO here
    // Their select bits are stored and read back but route nothing
    state_d.p2_out  = gpio_port2_out_in;
    state_d.p2_oe   = gpio_port2_oe_in;
    state_d.gpio_p2 = port2_pin_in;

    // Pin 7 is chosen by its alternate and select bits together
    case ({port2_alternate_select[pfs_pkg::PORT2_ALTERNATE_SELECT_PIN7 - pfs_pkg::ALT_LSB],
           p2_sel[pfs_pkg::P2_SEL_PIN7]})
      2'b10:   p27_func = pfs_pkg::PFS_P27_SPI_SCLK;
      2'b11:   p27_func = pfs_pkg::PFS_P27_UART_RTS;
      // Pair 01 has no function; GPIO keeps a stray write harmless
      2'b01:   p27_func = pfs_pkg::PFS_P27_GPIO;
      default: p27_func = pfs_pkg::PFS_P27_GPIO;
    endcase
    state_d.p27  = p27_func;
    state_d.sclk = 1'b0;

    case (p27_func)
      pfs_pkg::PFS_P27_SPI_SCLK:
      begin
        // Clock is two-way: master drives, slave listens
        state_d.p2_out[7] = serial_periph0_sclk_in;
        state_d.p2_oe[7]  = serial_periph0_sclk_oe_in;
        state_d.sclk      = port2_pin_in[7];
      end
      pfs_pkg::PFS_P27_UART_RTS:
      begin
        // RTS is output only, so the pad is always driven
        state_d.p2_out[7] = uart_unit1_rts_out_in;
        state_d.p2_oe[7]  = 1'b1;
      end
      pfs_pkg::PFS_P27_GPIO:
      begin
        state_d.p2_out[7] = gpio_port2_out_in[7];
        state_d.p2_oe[7]  = gpio_port2_oe_in[7];
      end
      default:
      begin
        state_d.p2_oe[7] = 1'b0;
      end
    endcase
  end

  // Readies come up high so the first request after reset is taken at once
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q            <= '0;
      state_q.port1_ctrl <= pfs_pkg::PORT1_CTRL_RESET;
      state_q.port2_ctrl <= pfs_pkg::PORT2_CTRL_RESET;
      state_q.awready    <= 1'b1;
      state_q.wready     <= 1'b1;
      state_q.arready    <= 1'b1;
      state_q.p27        <= pfs_pkg::PFS_P27_GPIO;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Bus outputs
  assign s_axi_awready_out = state_q.awready;
  assign s_axi_wready_out  = state_q.wready;
  assign s_axi_bvalid_out  = state_q.bvalid;
  assign s_axi_bresp_out   = state_q.bresp;
  assign s_axi_arready_out = state_q.arready;
  assign s_axi_rvalid_out  = state_q.rvalid;
  assign s_axi_rdata_out   = state_q.rdata;
  assign s_axi_rresp_out   = state_q.rresp;

  // Schmitt enables come straight from the control bits
  assign port1_schmitt_enable_out =
    state_q.port1_ctrl[pfs_pkg::SCHMITT_LSB +: 8];
  assign port2_schmitt_enable_out =
    state_q.port2_ctrl[pfs_pkg::SCHMITT_LSB +: 8];

  // Pin side
  assign port1_pin_out           = state_q.p1_out;
  assign port1_pin_oe_out        = state_q.p1_oe;
  assign port2_pin_out           = state_q.p2_out;
  assign port2_pin_oe_out        = state_q.p2_oe;
  assign gpio_port1_pin_out      = state_q.gpio_p1;
  assign gpio_port2_pin_out      = state_q.gpio_p2;
  assign pwm_unit1_brake_in0_out = state_q.brake1;
  assign pwm_unit0_brake_in0_out = state_q.brake0;
  assign serial_periph0_sclk_out = state_q.sclk;

  // Decoded view for debug and the GPIO block
  assign port1_function_select_out = state_q.port1_ctrl[pfs_pkg::SEL_LSB +: 8];
  assign port2_pin7_function_out   = state_q.p27;

endmodule : pfs_pin_select

// ---- pfs_pin_select_properties.sv ----
// Purpose: Port checks for the pin function select block
// Assumes: Select bits lead the pins by one edge; pin 7 code moves with the pins
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
module pfs_checker (
  // Bus
  input wire logic        clk_in, rst_n_in, s_axi_bvalid_out, s_axi_arvalid_in,
  input wire logic        s_axi_arready_out, s_axi_rvalid_out,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out, port2_pin7_function_out,
  // Pins and peripherals
  input wire logic [7:0]  port1_pin_in, port1_pin_out, port1_pin_oe_out, port2_pin_in,
  input wire logic [7:0]  port2_pin_out, port2_pin_oe_out, gpio_port1_out_in,
  input wire logic [7:0]  gpio_port1_oe_in, gpio_port2_out_in, port1_function_select_out,
  input wire logic [7:0]  port1_schmitt_enable_out, port2_schmitt_enable_out,
  input wire logic [5:0]  pwm_unit1_out_in,
  input wire logic        pwm_unit1_brake_in0_out, pwm_unit0_brake_in0_out,
  input wire logic        uart_unit1_rts_out_in, serial_periph0_sclk_in,
  input wire logic        serial_periph0_sclk_oe_in, serial_periph0_sclk_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] sel;
  logic [1:0] fn;
  logic       live_q;
  assign sel = port1_function_select_out;
  assign fn  = port2_pin7_function_out;
  // First edge after release still shows reset values
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;

  a_brake1_route: assert property (
    pwm_unit1_brake_in0_out == ($past(sel[7]) & $past(port1_pin_in[7])))
    else $error("brake 1 routing wrong");
  a_brake0_route: assert property (
    pwm_unit0_brake_in0_out == ($past(sel[6]) & $past(port1_pin_in[6])))
    else $error("brake 0 routing wrong");
  a_pwm_drive: assert property (
    live_q |-> port1_pin_out[5:0] == (($past(sel[5:0]) & $past(pwm_unit1_out_in))
      | (~$past(sel[5:0]) & $past(gpio_port1_out_in[5:0]))))
    else $error("port 1 drive wrong");
  a_pwm_enable: assert property (
    live_q |-> port1_pin_oe_out[5:0] == ($past(sel[5:0]) | $past(gpio_port1_oe_in[5:0])))
    else $error("port 1 enable wrong");
  a_uart_rts_route: assert property (
    fn == pfs_pkg::PFS_P27_UART_RTS |->
      port2_pin_oe_out[7] && port2_pin_out[7] == $past(uart_unit1_rts_out_in))
    else $error("rts routing wrong");
  a_spi_clk_route: assert property (
    fn == pfs_pkg::PFS_P27_SPI_SCLK |->
      port2_pin_oe_out[7] == $past(serial_periph0_sclk_oe_in)
      && port2_pin_out[7] == $past(serial_periph0_sclk_in)
      && serial_periph0_sclk_out == $past(port2_pin_in[7]))
    else $error("spi clock routing wrong");
  a_pin7_gpio: assert property (
    live_q && fn == pfs_pkg::PFS_P27_GPIO |->
      port2_pin_out[7] == $past(gpio_port2_out_in[7]) && !serial_periph0_sclk_out)
    else $error("pin 7 gpio wrong");
  a_schmitt_quiet: assert property (
    $changed({port1_schmitt_enable_out, port2_schmitt_enable_out})
      |-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
    else $error("schmitt changed without write");
  a_read_unmapped: assert property (
    s_axi_arvalid_in && s_axi_arready_out && !(s_axi_araddr_in[11:2] inside {10'h00d, 10'h00e})
      |=> s_axi_rresp_out == pfs_pkg::RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read wrong");
  a_reserved_zero: assert property (
    s_axi_rvalid_out |-> (s_axi_rdata_out & 32'hff00_0e00) == 32'h0)
    else $error("reserved bits read nonzero");

  c_brake: cover property ($past(sel[7]) && pwm_unit1_brake_in0_out);
  c_rts: cover property (fn == pfs_pkg::PFS_P27_UART_RTS);
  c_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == pfs_pkg::RESP_SLVERR);
endmodule : pfs_checker

bind pfs_pin_select pfs_checker chk (
  .clk_in, .rst_n_in, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_araddr_in, .s_axi_rdata_out, .s_axi_rresp_out,
  .port2_pin7_function_out, .port1_pin_in, .port1_pin_out, .port1_pin_oe_out, .port2_pin_in,
  .port2_pin_out, .port2_pin_oe_out, .gpio_port1_out_in, .gpio_port1_oe_in,
  .gpio_port2_out_in, .port1_function_select_out, .port1_schmitt_enable_out,
  .port2_schmitt_enable_out, .pwm_unit1_out_in, .pwm_unit1_brake_in0_out,
  .pwm_unit0_brake_in0_out, .uart_unit1_rts_out_in, .serial_periph0_sclk_in,
  .serial_periph0_sclk_oe_in, .serial_periph0_sclk_out
);

// ---- pfs_pad_model.sv ----
// Purpose: Pads and far-side drivers of ports 1 and 2
// Assumes: Far side drives every pad the block leaves undriven
// Notes:   No float modelled; a released pad takes the far-side level
`timescale 1ns/10ps
module pfs_pad_model (
  // Block side and far side
  input  wire logic [7:0] p1_drv_in, p1_oe_in, p1_ext_in,
  input  wire logic [7:0] p2_drv_in, p2_oe_in, p2_ext_in,
  // Resolved levels
  output logic      [7:0] p1_lvl_out, p2_lvl_out
);
  assign p1_lvl_out = (p1_oe_in & p1_drv_in) | (~p1_oe_in & p1_ext_in);
  assign p2_lvl_out = (p2_oe_in & p2_drv_in) | (~p2_oe_in & p2_ext_in);
endmodule : pfs_pad_model

// ---- pfs_pin_select_bench.sv ----
// Purpose: Self-checking bench for the pin function select block
// Assumes: Bus answers come when they come; a watchdog cuts hangs
// Notes:   Inputs held steady so pin checks see settled values
`timescale 1ns/10ps
module pfs_pin_select_bench;
  logic        clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, serial_periph0_sclk_in;
  logic        serial_periph0_sclk_oe_in, uart_unit1_rts_out_in;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, pwm_unit1_brake_in0_out, pwm_unit0_brake_in0_out;
  logic        serial_periph0_sclk_out;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, port2_pin7_function_out;
  logic [5:0]  pwm_unit1_out_in;
  logic [7:0]  gpio_port1_out_in, gpio_port1_oe_in, gpio_port2_out_in, gpio_port2_oe_in;
  logic [7:0]  port1_pin_in, port1_pin_out, port1_pin_oe_out, port1_schmitt_enable_out;
  logic [7:0]  port2_pin_in, port2_pin_out, port2_pin_oe_out, port2_schmitt_enable_out;
  logic [7:0]  gpio_port1_pin_out, gpio_port2_pin_out, port1_function_select_out;
  logic [7:0]  ext1, ext2;
  int          fails, n_tests;

  pfs_pin_select uut (
    .clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .port1_pin_in, .port1_pin_out, .port1_pin_oe_out,
    .port1_schmitt_enable_out, .port2_pin_in, .port2_pin_out, .port2_pin_oe_out,
    .port2_schmitt_enable_out, .gpio_port1_out_in, .gpio_port1_oe_in,
    .gpio_port2_out_in, .gpio_port2_oe_in, .gpio_port1_pin_out, .gpio_port2_pin_out,
    .pwm_unit1_out_in, .pwm_unit1_brake_in0_out, .pwm_unit0_brake_in0_out,
    .serial_periph0_sclk_in, .serial_periph0_sclk_oe_in, .serial_periph0_sclk_out,
    .uart_unit1_rts_out_in, .port1_function_select_out, .port2_pin7_function_out
  );
  pfs_pad_model pads (
    .p1_drv_in(port1_pin_out), .p1_oe_in(port1_pin_oe_out), .p1_ext_in(ext1),
    .p2_drv_in(port2_pin_out), .p2_oe_in(port2_pin_oe_out), .p2_ext_in(ext2),
    .p1_lvl_out(port1_pin_in), .p2_lvl_out(port2_pin_in)
  );
  always #50 clk_in = ~clk_in;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_bready_in  <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp_out));
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in  <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    chk("rdata", e, s_axi_rdata_out);
    chk("rresp", 32'(er), 32'(s_axi_rresp_out));
  endtask : rd

  // Pins lag the control register by one edge
  task settle;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  task t_port1;
    wr(12'h034, 32'hffff_ffff, pfs_pkg::RESP_OKAY);
    rd(12'h034, 32'h00ff_00ff, pfs_pkg::RESP_OKAY);
    settle();
    chk("p1_schmitt", 32'h0000_00ff, 32'(port1_schmitt_enable_out));
    chk("brakes", 32'h3, 32'({pwm_unit1_brake_in0_out, pwm_unit0_brake_in0_out}));
    chk("p1_pwm", 32'(pwm_unit1_out_in), 32'(port1_pin_out[5:0]));
    chk("p1_oe", 32'h3f, 32'(port1_pin_oe_out));
    chk("p1_sel", 32'hff, 32'(port1_function_select_out));
    chk("gpio_p1", 32'he5, 32'(gpio_port1_pin_out));
    wr(12'h034, 32'h0000_0040, pfs_pkg::RESP_OKAY);
    settle();
    chk("p1_schmitt", 32'h0, 32'(port1_schmitt_enable_out));
    chk("brakes", 32'h1, 32'({pwm_unit1_brake_in0_out, pwm_unit0_brake_in0_out}));
    chk("p1_gpio", 32'(gpio_port1_out_in[5:0]), 32'(port1_pin_out[5:0]));
    chk("p1_oe", 32'h8f, 32'(port1_pin_oe_out));
    chk("gpio_p1", 32'h4a, 32'(gpio_port1_pin_out));
  endtask : t_port1

  task automatic t_port2;
    logic [31:0] dv [5] = '{32'h00a5_8000, 32'h005a_8080, 32'hffff_ffff, 32'h80, 32'h0};
    logic [4:0]  ev [5] = '{5'h09, 5'h16, 5'h16, 5'h04, 5'h04};
    for (int i = 0; i < 5; i++)
    begin
      wr(12'h038, dv[i], pfs_pkg::RESP_OKAY);
      rd(12'h038, dv[i] & 32'h00ff_f1ff, pfs_pkg::RESP_OKAY);
      settle();
      chk("p2_schmitt", 32'(dv[i][23:16]), 32'(port2_schmitt_enable_out));
      chk("p27", 32'(ev[i]), 32'({port2_pin7_function_out, port2_pin_oe_out[7],
          port2_pin_out[7], serial_periph0_sclk_out}));
      chk("p2_low", 32'(gpio_port2_out_in[6:0]), 32'(port2_pin_out[6:0]));
      chk("p2_oe_low", 32'h70, 32'(port2_pin_oe_out[6:0]));
      chk("gpio_p2", dv[i][15] ? 32'h90 : 32'h10, 32'(gpio_port2_pin_out));
    end
  endtask : t_port2

  task t_unmapped;
    wr(12'h03c, 32'hffff_ffff, pfs_pkg::RESP_SLVERR);
    rd(12'h03c, 32'h0, pfs_pkg::RESP_SLVERR);
    rd(12'h034, 32'h0000_0040, pfs_pkg::RESP_OKAY);
  endtask : t_unmapped

  task t_reset_values;
    rd(12'h034, 32'h0, pfs_pkg::RESP_OKAY);
    rd(12'h038, 32'h0, pfs_pkg::RESP_OKAY);
    chk("reset_pins", 32'h0, 32'({port1_schmitt_enable_out, port2_schmitt_enable_out,
        port2_pin7_function_out}));
  endtask : t_reset_values

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
    {s_axi_wdata_in, fails, n_tests} = '0;
    s_axi_wstrb_in = 4'hf;
    {serial_periph0_sclk_in, serial_periph0_sclk_oe_in, uart_unit1_rts_out_in} = 3'h1;
    {gpio_port1_out_in, gpio_port1_oe_in, ext1} = {8'h5a, 8'hcf, 8'hc0};
    {gpio_port2_out_in, gpio_port2_oe_in, ext2} = {8'h16, 8'hf0, 8'h80};
    pwm_unit1_out_in = 6'h25;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset_values();
    t_port1();
    t_port2();
    t_unmapped();
    wr(12'h038, 32'h00ff_f1ff, pfs_pkg::RESP_OKAY);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset_values();
    tally_and_finish();
  end

  // Run needs well under 400 cycles
  initial
  begin
    repeat (3000) @(posedge clk_in);
    fails++;
    tally_and_finish();
  end
endmodule : pfs_pin_select_bench
